// file: verilog/dfs_regs.vh
`ifndef DFS_REGS_VH
`define DFS_REGS_VH

// Status byte addresses: bits [6:1] of the address byte.
`define DFS_ADDR_GLOBAL      6'h13
`define DFS_ADDR_OC_1_4      6'h16
`define DFS_ADDR_OC_5_8      6'h1a
// Address byte fields.
`define DFS_ACCESS_BIT       7
`define DFS_ADDR_HI          6
`define DFS_ADDR_LO          1
// Global status field positions.
`define DFS_G_PROTO          7
`define DFS_G_LOAD           6
`define DFS_G_UV             5
`define DFS_G_OV             4
`define DFS_G_NO_POWER_ON_RESET_FLAG           3
`define DFS_G_TSD            2
`define DFS_G_TPW            1
`define DFS_G_RSVD           0
// Reset values and frame length.
`define DFS_STATUS_RESET     8'h00
`define DFS_FRAME_BITS       5'h10
`define DFS_FRAME_OVER       5'h11
`define DFS_ADDR_LAST        5'h07
`define DFS_CNT_ZERO         5'h00
`define DFS_CNT_ONE          5'h01
`define DFS_SWITCHES         16
`define DFS_BYTE_SWITCHES    8

`endif

// file: verilog/dfs_sync.v
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser; the first stage feeds only the second.
// The reset value matches the idle level of the pin, so that no false
// edge is seen when reset lets go.
module dfs_sync #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst,
  input  wire d,
  output reg  q
);
  reg meta_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // dfs_sync

`default_nettype wire

// file: verilog/dfs_status_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "dfs_regs.vh"

// Overview of operation
// R1: Protocol error sets sticky global bit seven.
// R2: Load summary is OR of switch faults.
// R3: Summary read-only, drops when faults cleared.
// R4: Overcurrent keeps faulty switch latched off.
// R5: Undervoltage latches bit five, outputs off.
// R6: Overvoltage latches bit four, outputs off.
// R7: Bit three zero after power-on reset.
// R8: Thermal shutdown latches bit two, outputs off.
// R9: Prewarning sets bit one, outputs stay on.
// R10: Bit zero always reads zero.
// R11: First byte pairs bridges one to four.
// R12: Second byte pairs bridges five to eight.
// R13: High-side overcurrent latches flag, disables switch.
// R14: Low-side overcurrent latches flag, disables switch.
// R15: Overcurrent flags reset zero, read-clear type.
// R16: Frame: address byte, data byte; bit7 clears.
// R17: Only the controller clears status bits.
// R18: Disabled switch stays off until cleared.
module dfs_status_bank (
  // Clock and reset
  input  wire        MCLK,
  input  wire        RST,
  // Serial link pins
  input  wire        CSN,
  input  wire        SCLK,
  input  wire        SDI,
  output reg         SDO,
  output reg         SDO_OEN,
  // Fault event inputs from analog monitors
  input  wire        PROTO_ERR,
  input  wire        SUPPLY_LOW,
  input  wire        SUPPLY_HIGH,
  input  wire        THERM_SHUT,
  input  wire        THERM_WARN,
  input  wire [15:0] OC_EVENT,
  input  wire        OPEN_LOAD_ANY,
  // Switch control
  input  wire [15:0] SWITCH_REQ,
  output reg  [15:0] SWITCH_ON
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  wire csn_s;
  wire sclk_s;
  wire sdi_s;
  wire proto_s;
  wire uv_s;
  wire ov_s;
  wire tsd_s;
  wire tpw_s;
  wire ol_s;
  wire [15:0] oc_s;

  // Chip select resets high, its idle level; a low reset value would
  // fake a frame start and drive the data pin just after reset.
  dfs_sync #(.RST_VAL(1'b1)) u_csn (
    .clk (MCLK),
    .rst (RST),
    .d   (CSN),
    .q   (csn_s)
  );

  dfs_sync u_sclk (
    .clk (MCLK),
    .rst (RST),
    .d   (SCLK),
    .q   (sclk_s)
  );

  dfs_sync u_sdi (
    .clk (MCLK),
    .rst (RST),
    .d   (SDI),
    .q   (sdi_s)
  );

  dfs_sync u_prot (
    .clk (MCLK),
    .rst (RST),
    .d   (PROTO_ERR),
    .q   (proto_s)
  );

  dfs_sync u_uv (
    .clk (MCLK),
    .rst (RST),
    .d   (SUPPLY_LOW),
    .q   (uv_s)
  );

  dfs_sync u_ov (
    .clk (MCLK),
    .rst (RST),
    .d   (SUPPLY_HIGH),
    .q   (ov_s)
  );

  dfs_sync u_tsd (
    .clk (MCLK),
    .rst (RST),
    .d   (THERM_SHUT),
    .q   (tsd_s)
  );

  dfs_sync u_tpw (
    .clk (MCLK),
    .rst (RST),
    .d   (THERM_WARN),
    .q   (tpw_s)
  );

  // Open-load flags live elsewhere; only their summary crosses here.
  dfs_sync u_ol (
    .clk (MCLK),
    .rst (RST),
    .d   (OPEN_LOAD_ANY),
    .q   (ol_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `DFS_SWITCHES; gi = gi + 1) begin : g_ocs
      dfs_sync u_oc (
        .clk (MCLK),
        .rst (RST),
        .d   (OC_EVENT[gi]),
        .q   (oc_s[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Serial edge detection
  // ==========================================================
  reg sclk_d_reg;
  reg csn_d_reg;

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sclk_d_reg <= 1'b0;
      csn_d_reg  <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      csn_d_reg  <= csn_s;
    end
  end

  wire rise_sclk = sclk_s & ~sclk_d_reg & ~csn_s;
  wire fall_sclk = ~sclk_s & sclk_d_reg & ~csn_s;
  wire frame_beg = csn_d_reg & ~csn_s;
  wire frame_end = ~csn_d_reg & csn_s;

  // ==========================================================
  // Frame shifter
  // ==========================================================
  // Mode 0: data sampled on rising SCLK, shifted out on falling.
  reg [4:0]  bit_cnt_reg;
  reg [15:0] shift_in_reg;
  reg [7:0]  shift_out_reg;
  reg [7:0]  addr_reg;
  reg        addr_done_reg;

  // Status bytes.
  reg proto_reg;
  reg uv_reg;
  reg ov_reg;
  reg no_power_on_reset_flag_reg;
  reg tsd_reg;
  reg tpw_reg;
  reg [15:0] oc_reg;

  wire load_fault = (|oc_reg) | ol_s; // R2 R3

  function [7:0] read_byte;
    input [5:0] a;
    begin
      case (a)
        `DFS_ADDR_GLOBAL:
          read_byte = {proto_reg, load_fault, uv_reg, ov_reg,
                       no_power_on_reset_flag_reg, tsd_reg, tpw_reg, 1'b0}; // R10
        `DFS_ADDR_OC_1_4: read_byte = oc_reg[7:0];  // R11
        `DFS_ADDR_OC_5_8: read_byte = oc_reg[15:8]; // R12
        default:          read_byte = `DFS_STATUS_RESET;
      endcase
    end
  endfunction

  wire [7:0] addr_now = {shift_in_reg[6:0], sdi_s};

  // Next-state values of the frame shifter.
  reg [4:0]  bit_cnt_next;
  reg [15:0] shift_in_next;
  reg [7:0]  shift_out_next;
  reg [7:0]  addr_next;
  reg        addr_done_next;
  reg        sdo_next;

  always @* begin
    bit_cnt_next   = bit_cnt_reg;
    shift_in_next  = shift_in_reg;
    shift_out_next = shift_out_reg;
    addr_next      = addr_reg;
    addr_done_next = addr_done_reg;
    sdo_next       = SDO;
    if (frame_beg) begin
      bit_cnt_next   = `DFS_CNT_ZERO;
      addr_done_next = 1'b0;
      // The global byte goes out while the address byte comes in.
      shift_out_next = read_byte(`DFS_ADDR_GLOBAL);
      sdo_next       = proto_reg;
    end else if (rise_sclk) begin
      shift_in_next = {shift_in_reg[14:0], sdi_s};
      // Saturating one past a full frame keeps overlong frames visible.
      if (bit_cnt_reg != `DFS_FRAME_OVER)
        bit_cnt_next = bit_cnt_reg + `DFS_CNT_ONE;
      // The last address bit arrives now, so the byte is decoded at once.
      if (bit_cnt_reg == `DFS_ADDR_LAST) begin
        addr_next      = addr_now; // R16
        addr_done_next = 1'b1;
        shift_out_next = read_byte(addr_now[`DFS_ADDR_HI:`DFS_ADDR_LO]);
      end else begin
        shift_out_next = {shift_out_reg[6:0], 1'b0};
      end
    end else if (fall_sclk) begin
      sdo_next = shift_out_reg[7];
    end
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      bit_cnt_reg   <= `DFS_CNT_ZERO;
      shift_in_reg  <= 16'h0000;
      shift_out_reg <= 8'h00;
      addr_reg      <= 8'h00;
      addr_done_reg <= 1'b0;
      SDO           <= 1'b0;
      SDO_OEN       <= 1'b1;
    end else begin
      bit_cnt_reg   <= bit_cnt_next;
      shift_in_reg  <= shift_in_next;
      shift_out_reg <= shift_out_next;
      addr_reg      <= addr_next;
      addr_done_reg <= addr_done_next;
      SDO           <= sdo_next;
      SDO_OEN       <= csn_s;
    end
  end

  // Frame judged only at its end: exactly 16 clocks is valid.
  wire frame_ok  = frame_end & (bit_cnt_reg == `DFS_FRAME_BITS);
  wire frame_bad = frame_end & (bit_cnt_reg != `DFS_FRAME_BITS)
                   & (bit_cnt_reg != `DFS_CNT_ZERO);
  // Clear only on a valid frame with the access bit set. R16 R17
  wire do_clear  = frame_ok & addr_done_reg
                   & addr_reg[`DFS_ACCESS_BIT];
  wire clr_glob  = do_clear &
    (addr_reg[`DFS_ADDR_HI:`DFS_ADDR_LO] == `DFS_ADDR_GLOBAL);
  wire clr_oc1   = do_clear &
    (addr_reg[`DFS_ADDR_HI:`DFS_ADDR_LO] == `DFS_ADDR_OC_1_4);
  wire clr_oc2   = do_clear &
    (addr_reg[`DFS_ADDR_HI:`DFS_ADDR_LO] == `DFS_ADDR_OC_5_8);

  // ==========================================================
  // Sticky flags; a set in the clearing cycle wins.
  // ==========================================================
  // Next-state values of the status flags.
  reg        proto_next;
  reg        uv_next;
  reg        ov_next;
  reg        no_power_on_reset_flag_next;
  reg        tsd_next;
  reg        tpw_next;
  reg [15:0] oc_next;
  wire [15:0] clr_oc_mask;

  // Each overcurrent bit is cleared only by the byte that carries it.
  generate
    for (gi = 0; gi < `DFS_SWITCHES; gi = gi + 1) begin : g_clr
      assign clr_oc_mask[gi] = (gi < `DFS_BYTE_SWITCHES) ? clr_oc1
                                                         : clr_oc2;
    end
  endgenerate

  always @* begin
    proto_next = frame_bad | proto_s | (proto_reg & ~clr_glob); // R1
    uv_next    = uv_s  | (uv_reg  & ~clr_glob); // R5
    ov_next    = ov_s  | (ov_reg  & ~clr_glob); // R6
    tsd_next   = tsd_s | (tsd_reg & ~clr_glob); // R8
    tpw_next   = tpw_s | (tpw_reg & ~clr_glob); // R9
    // No event sets this bit; it reads 0 after reset and after a clear,
    // so a user cannot tell a reset from a clear by this bit alone.
    no_power_on_reset_flag_next  = no_power_on_reset_flag_reg & ~clr_glob; // R7
    oc_next    = oc_s | (oc_reg & ~clr_oc_mask); // R13 R14 R15
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      proto_reg <= 1'b0; // R1
      uv_reg    <= 1'b0;
      ov_reg    <= 1'b0;
      no_power_on_reset_flag_reg  <= 1'b0; // R7
      tsd_reg   <= 1'b0;
      tpw_reg   <= 1'b0;
      oc_reg    <= 16'h0000; // R15
    end else begin
      proto_reg <= proto_next;
      uv_reg    <= uv_next;
      ov_reg    <= ov_next;
      no_power_on_reset_flag_reg  <= no_power_on_reset_flag_next;
      tsd_reg   <= tsd_next;
      tpw_reg   <= tpw_next;
      oc_reg    <= oc_next;
    end
  end

  // ==========================================================
  // Switch enables
  // ==========================================================
  // Prewarning does not gate outputs; the supply and thermal faults do.
  wire all_off = uv_reg | ov_reg | tsd_reg; // R5 R6 R8 R9

  // The raw event also gates its switch, so the switch goes off one
  // cycle before the latched flag could do it.
  reg [15:0] switch_on_next;

  always @* begin
    switch_on_next = SWITCH_REQ & ~oc_reg & ~oc_s
                     & {`DFS_SWITCHES{~all_off}}; // R4 R13 R14 R18
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST)
      SWITCH_ON <= {`DFS_SWITCHES{1'b0}};
    else
      SWITCH_ON <= switch_on_next;
  end

endmodule // dfs_status_bank

`default_nettype wire

// file: bench/dfs_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Pin-level checks; inputs are synchronised, hence the slack.
module dfs_props (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        CSN,
  input wire logic        SDO_OEN,
  input wire logic        SUPPLY_LOW,
  input wire logic        SUPPLY_HIGH,
  input wire logic        THERM_SHUT,
  input wire logic [15:0] OC_EVENT,
  input wire logic [15:0] SWITCH_ON
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_held(x);
    x [*6];
  endsequence
  a_idle_release: assert property (CSN [*5] |-> SDO_OEN)
    else $error("pin driven while deselected");
  a_frame_drive: assert property (!CSN [*5] |-> !SDO_OEN)
    else $error("pin idle while selected");
  a_uv_off: assert property (s_held(SUPPLY_LOW) |-> !SWITCH_ON)
    else $error("outputs on in undervoltage");
  a_ov_off: assert property (s_held(SUPPLY_HIGH) |-> !SWITCH_ON)
    else $error("outputs on in overvoltage");
  a_tsd_off: assert property (s_held(THERM_SHUT) |-> !SWITCH_ON)
    else $error("outputs on in shutdown");
  a_hs_oc_off: assert property (s_held(OC_EVENT[1]) |-> !SWITCH_ON[1])
    else $error("high side on in overcurrent");
  a_ls_oc_off: assert property (s_held(OC_EVENT[8]) |-> !SWITCH_ON[8])
    else $error("low side on in overcurrent");
  a_latch_holds: assert property
    ($fell(OC_EVENT[1]) |-> !SWITCH_ON[1] [*4])
    else $error("switch back on before clear");
endmodule // dfs_props
bind dfs_status_bank dfs_props u_props (.MCLK(MCLK), .RST(RST), .CSN(CSN),
  .SDO_OEN(SDO_OEN), .SUPPLY_LOW(SUPPLY_LOW), .SUPPLY_HIGH(SUPPLY_HIGH),
  .THERM_SHUT(THERM_SHUT), .OC_EVENT(OC_EVENT), .SWITCH_ON(SWITCH_ON));
`default_nettype wire

// file: bench/dfs_master.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Serial controller; SCLK stands low outside frames.
module dfs_master (
  input  wire logic MCLK,
  input  wire logic SDO,
  output var logic  CSN,
  output var logic  SCLK,
  output var logic  SDI
);
  initial begin
    CSN = 1'b1;
    SCLK = 1'b0;
    SDI = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, input int nb,
                      output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge MCLK) CSN = 1'b0;
    for (int i = 0; i < nb; i++) begin
      SDI = (i < 16) ? tx[15-i] : 1'b0;
      repeat (4) @(negedge MCLK);
      SCLK = 1'b1;
      repeat (4) @(negedge MCLK);
      rx = {rx[14:0], SDO};
      SCLK = 1'b0;
    end
    repeat (4) @(negedge MCLK);
    CSN = 1'b1;
    SDI = ~SDI;
    repeat (8) @(negedge MCLK);
  endtask
endmodule // dfs_master
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Status bank bench.
module testbench;
  logic        MCLK = 1'b0;
  logic        RST = 1'b1;
  logic        CSN, SCLK, SDI, SDO, SDO_OEN;
  logic [5:0]  ev = 6'h00;
  logic [15:0] oc = 16'h0000, on, rx;
  int          n_errors = 0, compares = 0, cycles = 0;
  always #10 MCLK = ~MCLK;
  dfs_master m (.MCLK(MCLK), .SDO(SDO), .CSN(CSN), .SCLK(SCLK), .SDI(SDI));
  dfs_status_bank DUT (.MCLK(MCLK), .RST(RST), .CSN(CSN), .SCLK(SCLK),
    .SDI(SDI), .SDO(SDO), .SDO_OEN(SDO_OEN), .PROTO_ERR(ev[4]),
    .SUPPLY_LOW(ev[3]), .SUPPLY_HIGH(ev[2]), .THERM_SHUT(ev[1]),
    .THERM_WARN(ev[0]), .OC_EVENT(oc), .OPEN_LOAD_ANY(ev[5]),
    .SWITCH_REQ(16'hffff), .SWITCH_ON(on));
  task chk(input logic [15:0] g, e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task rd(input logic [7:0] a, e);
    m.xfer({a, 8'h00}, 16, rx);
    chk({8'h00, rx[7:0]}, {8'h00, e});
  endtask
  task t_reset;
    rd(8'h27, 8'h00);
    rd(8'h2d, 8'h00);
    rd(8'h35, 8'h00);
    rd(8'h01, 8'h00);
    chk(on, 16'hffff);
  endtask
  task t_oc;
    @(negedge MCLK) oc = 16'h0102;
    repeat (10) @(negedge MCLK);
    oc = 16'h0000;
    repeat (4) @(negedge MCLK);
    chk(on, 16'hfefd);
    rd(8'h27, 8'h40);
    rd(8'had, 8'h02);
    rd(8'h27, 8'h40);
    rd(8'hb5, 8'h01);
    rd(8'h27, 8'h00);
    rd(8'h2d, 8'h00);
    chk(on, 16'hffff);
  endtask
  task t_flags;
    int b[6] = '{1, 2, 4, 5, 7, 6};
    for (int i = 0; i < 6; i++) begin
      @(negedge MCLK) ev = 6'h01 << i;
      repeat (10) @(negedge MCLK);
      chk(on, (i > 0 && i < 4) ? 16'h0000 : 16'hffff);
      rd(8'h27, 8'h01 << b[i]);
      ev = 6'h00;
      rd(8'ha7, (i == 5) ? 8'h00 : 8'h01 << b[i]);
      rd(8'h27, 8'h00);
      chk(on, 16'hffff);
    end
  endtask
  task t_short;
    m.xfer(16'h2700, 12, rx);
    rd(8'ha7, 8'h80);
    rd(8'h27, 8'h00);
    m.xfer(16'ha700, 17, rx);
    rd(8'ha7, 8'h80);
    rd(8'h27, 8'h00);
  endtask
  task summarize;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 12000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      summarize;
    end
  end
  initial begin
    repeat (12) @(negedge MCLK);
    RST = 1'b0;
    repeat (4) @(negedge MCLK);
    t_reset;
    t_oc;
    t_flags;
    t_short;
    summarize;
  end
endmodule // testbench
`default_nettype wire
